// *** dual_slope_adc_pkg.sv ***
package dual_slope_adc_pkg;

    typedef enum logic [2:0] {
        ST_PRECHECK = 3'b000,
        ST_READY    = 3'b001,
        ST_ARM      = 3'b011,
        ST_RAMP_UP  = 3'b010,
        ST_RAMP_DN  = 3'b110,
        ST_CALC     = 3'b111
    } seq_state_type;

    typedef struct packed {
        logic cycle_request;
        logic threshold_compare;
    } pin_in_type;

    typedef struct packed {
        logic ramp_select;
        logic overrange;
        logic conv_done;
    } pin_out_type;

endpackage

// *** dual_slope_adc_regs.svh ***
// Notes on behaviour
// - ramp high, wait comparator low first
// - below threshold: raise conversion finished flag
// - cycle input: clear finished, ramp low
// - port bits: cycle 1, ramp 2, comparator 7
// - ramp-up starts on comparator rising edge
// - load start count, decrement per step
// - count zero: ramp high, then increment
// - increment until comparator back at threshold
// - ramp steps keep fixed 2:1 duration ratio
// - subtract one from upper count byte
// - result is 12-bit binary value
// - overrange: overrange, finished, ramp high together
// - no overrange: finished and ramp high only
// - ramp low selects unknown, high reference
`ifndef DUAL_SLOPE_ADC_REGS_SVH
`define DUAL_SLOPE_ADC_REGS_SVH

`define ADDR_W            8
`define OFS_CTRL          8'h00
`define OFS_PORT_VIEW     8'h04
`define OFS_RESULT        8'h08
`define OFS_IRQ_STATUS    8'h0c
`define OFS_IRQ_MASK      8'h10
`define OFS_COUNT         8'h14

`define CTRL_SW_CYCLE_BIT 0
`define PORT_CYCLE_BIT    1
`define PORT_RAMP_BIT     2
`define PORT_OVER_BIT     3
`define PORT_DONE_BIT     4
`define PORT_COMP_BIT     7
`define IRQ_DONE_BIT      0
`define IRQ_OVER_BIT      1
`define IRQ_W             2

`define COUNT_W           16
`define RESULT_W          12
`define RAMP_UP_START     16'h2000
`define OFFSET_SUB        16'h0100
`define FULL_SCALE        17'h00fff
`define COUNT_MAX         16'hffff

`define UP_STEP_CYCLES    4
`define STEP_RATIO        2
`define STEP_W            8

`define IRQ_MASK_RESET    2'h0
`define CTRL_RESET        32'h0000_0000

`endif

// *** dual_slope_adc_sequencer.sv ***
`timescale 1ns/100ps
`include "dual_slope_adc_regs.svh"
module dual_slope_adc_sequencer
    import dual_slope_adc_pkg::*;
#(
    parameter int UP_STEP_CYCLES = `UP_STEP_CYCLES,
    parameter int STEP_RATIO     = `STEP_RATIO
) (
    input  wire logic                 mclk,
    input  wire logic                 arst_n,
    input  wire logic                 ce,
    input  wire logic                 cycle_request_in,
    input  wire logic                 threshold_compare_in,
    output logic                      ramp_select_out,
    output logic                      overrange_out,
    output logic                      conv_done_out,
    output logic                      irq_out,
    input  wire logic [`ADDR_W-1:0]   addr,
    input  wire logic [31:0]          wr_data,
    input  wire logic                 wr_stb,
    input  wire logic                 rd_stb,
    output logic      [31:0]          rd_data
);
    localparam int DN_STEP_CYCLES = UP_STEP_CYCLES * STEP_RATIO;

    logic [1:0]            rst_sync_reg;
    logic                  rst_n;
    pin_in_type            pins;
    logic                  sync_cycle;
    logic                  sync_comp;
    logic                  comp_prev_reg;
    logic                  comp_rise;
    seq_state_type         state_reg;
    seq_state_type         state_next;
    logic [`COUNT_W-1:0]   count_reg;
    logic [`STEP_W-1:0]    step_reg;
    logic                  tick;
    pin_out_type           out_reg;
    logic [`RESULT_W-1:0]  result_reg;
    logic [16:0]           corrected;
    logic                  over_now;
    logic [31:0]           ctrl_reg;
    logic [`IRQ_W-1:0]     irq_status_reg;
    logic [`IRQ_W-1:0]     irq_mask_reg;
    logic [`IRQ_W-1:0]     irq_event;
    logic                  irq_reg;
    logic [31:0]           rd_data_reg;
    logic                  cycle_req;
    logic [7:0]            port_view;

    function automatic logic [`STEP_W-1:0] step_load(input int cycles);
        step_load = `STEP_W'(cycles - 1);
    endfunction

    function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    pin_sync u_sync_cycle (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .ce        (ce),
        .pin_in    (cycle_request_in),
        .level_reg (sync_cycle)
    );

    // comparator taken as above threshold until seen low, so pre-check cannot pass early
    pin_sync #(.RESET_LEVEL(1'b1)) u_sync_comp (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .ce        (ce),
        .pin_in    (threshold_compare_in),
        .level_reg (sync_comp)
    );
    assign pins = '{cycle_request: sync_cycle, threshold_compare: sync_comp};

    // matches the synchroniser reset level, no false rise after reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            comp_prev_reg <= 1'b1;
        end else if (ce) begin
            comp_prev_reg <= pins.threshold_compare;
        end
    end
    assign comp_rise = pins.threshold_compare && !comp_prev_reg;
    assign cycle_req = pins.cycle_request || ctrl_reg[`CTRL_SW_CYCLE_BIT];

    // offset correction on the upper byte, borrow means below zero
    assign corrected = {1'b0, count_reg} - {1'b0, `OFFSET_SUB};
    assign over_now  = !corrected[16] && (corrected > `FULL_SCALE);

    assign tick = (step_reg == '0);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_PRECHECK: if (!pins.threshold_compare) state_next = ST_READY;
            ST_READY:    if (cycle_req) state_next = ST_ARM;
            ST_ARM:      if (comp_rise) state_next = ST_RAMP_UP;
            ST_RAMP_UP:  if (tick && count_reg == `COUNT_W'(1)) state_next = ST_RAMP_DN;
            ST_RAMP_DN: begin
                // saturating count ends the cycle as an overrange
                if (!pins.threshold_compare || count_reg == `COUNT_MAX) begin
                    state_next = ST_CALC;
                end
            end
            ST_CALC:     state_next = ST_READY;
            default:     state_next = ST_PRECHECK;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_PRECHECK;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // step timer; ramp-down steps last STEP_RATIO times the ramp-up ones
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            step_reg <= '0;
        end else if (ce) begin
            if (state_reg == ST_ARM) begin
                step_reg <= step_load(UP_STEP_CYCLES);
            end else if (state_reg == ST_RAMP_UP && state_next == ST_RAMP_DN) begin
                step_reg <= step_load(DN_STEP_CYCLES);
            end else if (tick) begin
                step_reg <= (state_reg == ST_RAMP_DN) ? step_load(DN_STEP_CYCLES)
                                                      : step_load(UP_STEP_CYCLES);
            end else begin
                step_reg <= step_reg - `STEP_W'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (ce) begin
            if (state_reg == ST_ARM) begin
                count_reg <= `RAMP_UP_START;
            end else if (state_reg == ST_RAMP_UP && tick) begin
                count_reg <= count_reg - `COUNT_W'(1);
            end else if (state_reg == ST_RAMP_DN && state_next == ST_RAMP_DN && tick) begin
                count_reg <= count_reg + `COUNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            result_reg <= '0;
        end else if (ce && state_reg == ST_CALC) begin
            // negative readings clamp to zero, overrange to full scale
            if (corrected[16]) begin
                result_reg <= '0;
            end else if (over_now) begin
                result_reg <= '1;
            end else begin
                result_reg <= corrected[`RESULT_W-1:0];
            end
        end
    end

    // ramp low integrates the unknown, high the reference
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= '{ramp_select: 1'b1, overrange: 1'b0, conv_done: 1'b0};
        end else if (ce) begin
            unique case (state_next)
                ST_PRECHECK: out_reg.ramp_select <= 1'b1;
                ST_READY: begin
                    out_reg.ramp_select <= 1'b1;
                    out_reg.conv_done   <= 1'b1;
                    if (state_reg == ST_CALC) begin
                        out_reg.overrange <= over_now;
                    end
                end
                ST_ARM: begin
                    out_reg.ramp_select <= 1'b0;
                    out_reg.conv_done   <= 1'b0;
                    out_reg.overrange   <= 1'b0;
                end
                ST_RAMP_UP: out_reg.ramp_select <= 1'b0;
                ST_RAMP_DN: out_reg.ramp_select <= 1'b1;
                ST_CALC:    out_reg.ramp_select <= 1'b1;
                default:    out_reg.ramp_select <= 1'b1;
            endcase
        end
    end

    assign ramp_select_out = out_reg.ramp_select;
    assign overrange_out   = out_reg.overrange;
    assign conv_done_out   = out_reg.conv_done;

    // register view in the documented port layout
    always_comb begin
        port_view = 8'h00;
        port_view[`PORT_CYCLE_BIT] = pins.cycle_request;
        port_view[`PORT_RAMP_BIT]  = out_reg.ramp_select;
        port_view[`PORT_OVER_BIT]  = out_reg.overrange;
        port_view[`PORT_DONE_BIT]  = out_reg.conv_done;
        port_view[`PORT_COMP_BIT]  = pins.threshold_compare;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg     <= `CTRL_RESET;
            irq_mask_reg <= `IRQ_MASK_RESET;
        end else if (ce && wr_stb) begin
            if (hit(addr, `OFS_CTRL)) begin
                ctrl_reg <= {31'h0, wr_data[`CTRL_SW_CYCLE_BIT]};
            end
            if (hit(addr, `OFS_IRQ_MASK)) begin
                irq_mask_reg <= wr_data[`IRQ_W-1:0];
            end
        end
    end

    assign irq_event[`IRQ_DONE_BIT] = (state_reg == ST_CALC);
    assign irq_event[`IRQ_OVER_BIT] = (state_reg == ST_CALC) && over_now;

    // a new event wins over a same-cycle write-one-to-clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_reg <= '0;
            irq_reg        <= 1'b0;
        end else if (ce) begin
            irq_status_reg <= (irq_status_reg & ~((wr_stb && hit(addr, `OFS_IRQ_STATUS))
                              ? wr_data[`IRQ_W-1:0] : '0)) | irq_event;
            irq_reg        <= |((irq_status_reg | irq_event) & irq_mask_reg);
        end
    end
    assign irq_out = irq_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= 32'h0;
        end else if (ce) begin
            rd_data_reg <= 32'h0;
            if (rd_stb) begin
                unique case (addr)
                    `OFS_CTRL:       rd_data_reg <= ctrl_reg;
                    `OFS_PORT_VIEW:  rd_data_reg <= {21'h0, state_reg, port_view};
                    `OFS_RESULT:     rd_data_reg <= {20'h0, result_reg};
                    `OFS_IRQ_STATUS: rd_data_reg <= {30'h0, irq_status_reg};
                    `OFS_IRQ_MASK:   rd_data_reg <= {30'h0, irq_mask_reg};
                    `OFS_COUNT:      rd_data_reg <= {16'h0, count_reg};
                    default:         rd_data_reg <= 32'h0;
                endcase
            end
        end
    end
    assign rd_data = rd_data_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence seq_enter_down;
        ce && state_reg == ST_RAMP_UP ##1 state_reg == ST_RAMP_DN;
    endsequence

    sequence seq_finish;
        ce && state_reg == ST_CALC ##1 state_reg == ST_READY;
    endsequence

    chk_precheck_ramp: assert property (
        state_reg == ST_PRECHECK |-> out_reg.ramp_select && !out_reg.conv_done)
        else $error("ramp not high during pre-check");
    chk_ready_done: assert property (
        ce && state_reg == ST_PRECHECK && !pins.threshold_compare |=> out_reg.conv_done)
        else $error("finished flag missing after pre-check");
    chk_cycle_start: assert property (
        ce && state_reg == ST_READY && cycle_req |=> !out_reg.ramp_select && !out_reg.conv_done)
        else $error("cycle request did not start conversion");
    chk_port_bits: assert property (
        port_view[2] == out_reg.ramp_select && port_view[7] == pins.threshold_compare)
        else $error("port bit mapping wrong");
    chk_rise_loads: assert property (
        ce && state_reg == ST_ARM && !comp_rise |=> state_reg == ST_ARM && count_reg == `RAMP_UP_START)
        else $error("ramp-up began without rising comparator");
    chk_up_decrement: assert property (
        ce && state_reg == ST_RAMP_UP && tick |=> count_reg == $past(count_reg) - `COUNT_W'(1))
        else $error("ramp-up count did not decrement");
    chk_down_ramp: assert property (
        seq_enter_down |-> out_reg.ramp_select && count_reg == '0)
        else $error("ramp-down entered wrongly");
    chk_step_ratio: assert property (
        seq_enter_down |-> step_reg == step_load(DN_STEP_CYCLES))
        else $error("ramp-down step length wrong");
    chk_over_flags: assert property (
        ce && state_reg == ST_CALC && over_now |=> out_reg.overrange && out_reg.conv_done
        && out_reg.ramp_select)
        else $error("overrange outputs not raised together");
    chk_normal_finish: assert property (
        seq_finish |-> out_reg.conv_done && out_reg.ramp_select && (out_reg.overrange
        == $past(over_now)))
        else $error("normal finish outputs wrong");
    chk_result_value: assert property (
        ce && state_reg == ST_CALC && !corrected[16] && !over_now
        |=> result_reg == `RESULT_W'($past(count_reg) - `OFFSET_SUB)
        && $past(count_reg[15:8]) != 8'h00)
        else $error("offset correction wrong");
endmodule

// *** dual_slope_adc_sequencer_tb.sv ***
`timescale 1ns/100ps
`include "dual_slope_adc_regs.svh"
`define CHECK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("ERROR t=%0t got %h expected %h", $time, (got), (exp)); \
        end \
    end
module dual_slope_adc_sequencer_tb;
    logic               mclk;
    logic               arst_n;
    logic               ce;
    logic               cycle_request_in;
    logic               threshold_compare_in;
    logic               ramp_select_out;
    logic               overrange_out;
    logic               conv_done_out;
    logic               irq_out;
    logic [`ADDR_W-1:0] addr;
    logic [31:0]        wr_data;
    logic               wr_stb;
    logic               rd_stb;
    logic [31:0]        rd_data;
    logic [15:0]        down_cycles;
    logic               hold_high;
    logic [31:0]        d;
    int                 up_cnt;
    int                 n;
    int                 fail_count;
    int                 check_count;

    // short ramp-up step keeps the run near 36k cycles
    dual_slope_adc_sequencer #(.UP_STEP_CYCLES(1), .STEP_RATIO(2)) dual_slope_adc_sequencer_i (
        .mclk                 (mclk),
        .arst_n               (arst_n),
        .ce                   (ce),
        .cycle_request_in     (cycle_request_in),
        .threshold_compare_in (threshold_compare_in),
        .ramp_select_out      (ramp_select_out),
        .overrange_out        (overrange_out),
        .conv_done_out        (conv_done_out),
        .irq_out              (irq_out),
        .addr                 (addr),
        .wr_data              (wr_data),
        .wr_stb               (wr_stb),
        .rd_stb               (rd_stb),
        .rd_data              (rd_data)
    );

    integrator_model integrator_model_i (
        .mclk              (mclk),
        .ramp_select       (ramp_select_out),
        .down_cycles       (down_cycles),
        .hold_high         (hold_high),
        .threshold_compare (threshold_compare_in)
    );

    always #12.5 mclk = ~mclk;

    // cycles from comparator rise to ramp high, held through ramp-down
    always @(posedge mclk) begin
        if (!threshold_compare_in) begin
            up_cnt <= 0;
        end else if (!ramp_select_out) begin
            up_cnt <= up_cnt + 1;
        end
    end

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr    <= a;
        wr_data <= v;
        wr_stb  <= 1'b1;
        @(posedge mclk);
        wr_stb  <= 1'b0;
    endtask

    task automatic rd(input logic [`ADDR_W-1:0] a, output logic [31:0] v);
        @(posedge mclk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        v = rd_data;
    endtask

    // which 0 watches ramp select, 1 watches conversion finished
    task automatic wait_for(input int which, input logic val, input int lim, output int cnt);
        cnt = 0;
        while (((which == 0) ? ramp_select_out : conv_done_out) !== val) begin
            @(posedge mclk);
            #1;
            cnt++;
            if (cnt > lim) begin
                fail_count++;
                $display("ERROR t=%0t wait ran out", $time);
                summarize();
            end
        end
    endtask

    task automatic convert(input logic sw, input logic [15:0] k, output logic [31:0] res);
        int c;
        down_cycles <= {k[14:0], 1'b0};
        if (sw) begin
            wr(`OFS_CTRL, 32'h1);
        end else begin
            @(posedge mclk);
            cycle_request_in <= 1'b1;
        end
        wait_for(0, 1'b0, 20, c);
        `CHECK(conv_done_out, 1'b0)
        `CHECK(overrange_out, 1'b0)
        if (sw) begin
            wr(`OFS_CTRL, 32'h0);
        end else begin
            @(posedge mclk);
            cycle_request_in <= 1'b0;
        end
        wait_for(0, 1'b1, 8300, c);
        `CHECK((up_cnt >= 8193) && (up_cnt <= 8200), 1'b1)
        wait_for(1, 1'b1, 2 * int'(k) + 60, c);
        `CHECK(ramp_select_out, 1'b1)
        rd(`OFS_RESULT, res);
    endtask

    initial begin
        mclk = 1'b0;
        arst_n = 1'b0;
        ce = 1'b1;
        cycle_request_in = 1'b0;
        addr = '0;
        wr_data = 32'h0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        hold_high = 1'b1;
        down_cycles = 16'h0014;
        fail_count = 0;
        check_count = 0;
        repeat (4) @(posedge mclk);
        #1;
        `CHECK(ramp_select_out, 1'b1)
        `CHECK(overrange_out, 1'b0)
        `CHECK(conv_done_out, 1'b0)
        `CHECK(irq_out, 1'b0)
        @(posedge mclk);
        arst_n <= 1'b1;
        repeat (30) @(posedge mclk);
        #1;
        `CHECK(conv_done_out, 1'b0)
        `CHECK(ramp_select_out, 1'b1)
        @(posedge mclk);
        hold_high <= 1'b0;
        wait_for(1, 1'b1, 60, n);
        `CHECK(ramp_select_out, 1'b1)
        rd(`OFS_PORT_VIEW, d);
        `CHECK(d[10:0], 11'h114)
        rd(8'h20, d);
        `CHECK(d, 32'h0)
        rd(`OFS_IRQ_MASK, d);
        `CHECK(d, 32'h0)
        // nominal reading: count near k, minus the offset step
        convert(1'b0, 16'd1000, d);
        `CHECK((d >= 32'd743) && (d <= 32'd748), 1'b1)
        `CHECK(overrange_out, 1'b0)
        `CHECK(irq_out, 1'b0)
        rd(`OFS_COUNT, d);
        `CHECK((d >= 32'd999) && (d <= 32'd1004), 1'b1)
        wr(`OFS_IRQ_MASK, 32'h3);
        @(posedge mclk);
        #1;
        `CHECK(irq_out, 1'b1)
        // beyond full scale after the offset step
        convert(1'b0, 16'd4400, d);
        `CHECK(d, 32'h0000_0fff)
        `CHECK(overrange_out, 1'b1)
        `CHECK(conv_done_out, 1'b1)
        rd(`OFS_IRQ_STATUS, d);
        `CHECK(d[1:0], 2'h3)
        wr(`OFS_IRQ_STATUS, 32'h3);
        @(posedge mclk);
        #1;
        `CHECK(irq_out, 1'b0)
        rd(`OFS_IRQ_STATUS, d);
        `CHECK(d[1:0], 2'h0)
        // software request, reading below the offset clamps to zero
        convert(1'b1, 16'd100, d);
        `CHECK(d, 32'h0)
        `CHECK(overrange_out, 1'b0)
        `CHECK(irq_out, 1'b1)
        // clock enable low: a write must be ignored
        @(posedge mclk);
        ce <= 1'b0;
        wr(`OFS_IRQ_MASK, 32'h0);
        @(posedge mclk);
        ce <= 1'b1;
        rd(`OFS_IRQ_MASK, d);
        `CHECK(d, 32'h3)
        `CHECK(irq_out, 1'b1)
        `CHECK(conv_done_out, 1'b1)
        summarize();
    end
endmodule

// *** integrator_model.sv ***
`timescale 1ns/100ps
module integrator_model (
    input  wire logic        mclk,
    input  wire logic        ramp_select,
    input  wire logic [15:0] down_cycles,
    input  wire logic        hold_high,
    output logic             threshold_compare
);
    int   timer;
    logic ramp_last;

    // starts above threshold so the pre-check wait is really exercised
    initial begin
        threshold_compare = 1'b1;
        timer = 0;
        ramp_last = 1'b1;
    end

    always @(posedge mclk) begin
        ramp_last <= ramp_select;
        if (hold_high) begin
            threshold_compare <= 1'b1;
            timer <= 0;
        end else if (!ramp_select) begin // low integrates the unknown, output climbs
            timer <= ramp_last ? 0 : timer + 1;
            if (!ramp_last && timer == 4) begin // crossing shows as a low to high edge
                threshold_compare <= 1'b1;
            end
        end else if (threshold_compare) begin // high discharges toward reference
            // restart the timer on the ramp edge, ramp-up cycles must not count here
            timer <= ramp_last ? timer + 1 : 0;
            if (ramp_last && timer >= int'(down_cycles)) begin // back at threshold
                threshold_compare <= 1'b0;
            end
        end
    end
endmodule

// *** pin_sync.sv ***
`timescale 1ns/100ps
module pin_sync
    import dual_slope_adc_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b0
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic pin_in,
    output logic      level_reg
);
    logic [2:0] stage_reg;

    // stage 0 feeds stage 1 only; level moves once stages 1 and 2 agree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage_reg <= {3{RESET_LEVEL}};
        end else if (ce) begin
            stage_reg <= {stage_reg[1], stage_reg[0], pin_in};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            level_reg <= RESET_LEVEL;
        end else if (ce && (stage_reg[1] == stage_reg[2])) begin
            level_reg <= stage_reg[2];
        end
    end
endmodule
